// ---- rtl/tsf_consts.svh ----
// Constants for the target status flag block: offsets, fields, resets.
// Assumes inclusion by bare name from the modules and the bench.
`ifndef TSF_CONSTS_SVH
`define TSF_CONSTS_SVH
// Register byte offsets
`define TSF_OFS_STATUS     8'h00
`define TSF_OFS_CONTROL    8'h04
`define TSF_OFS_ALT        8'h08
// Status field positions
`define TSF_ST_GCTYPE_LO   8
`define TSF_ST_GCIRQ       7
`define TSF_ST_BUSY        6
`define TSF_ST_REFUSED     5
`define TSF_ST_RXOF        4
`define TSF_ST_RXREQ       3
`define TSF_ST_TXREQ       2
`define TSF_ST_TXUR        1
`define TSF_ST_TXEE        0
// Control field positions
`define TSF_CT_GCCLR       0
`define TSF_CT_FORCE_FORCE_REFUSE_ACK  1
`define TSF_CT_EARLY_TX    2
`define TSF_CT_GC_EN       3
`define TSF_CT_HWGC_EN     4
// Reset values
`define TSF_RST_CONTROL    5'h00
`define TSF_RST_ALT        8'h00
`define TSF_RST_TXEE       1'b1
// General call type codes and second-byte commands
`define TSF_GC_NONE        2'h0
`define TSF_GC_RESET_PROG  2'h1
`define TSF_GC_PROG        2'h2
`define TSF_GC_HW          2'h3
`define TSF_GC_CMD_RESET   8'h06
`define TSF_GC_CMD_PROG    8'h04
`endif

// ---- rtl/tsf_pkg.sv ----
// Types shared by the target status flag block.
// Assumes the constants header is on the include path.
package tsf_pkg;
  // Same-clock events from the target shift engine
  typedef struct packed {
    logic start;        // start or repeated start seen
    logic stop;         // stop seen
    logic addr_match;   // address byte matched an id (pulse)
    logic addr_nomatch; // address byte matched nothing (pulse)
    logic rsta_nomatch; // address after repeated start missed (pulse)
    logic dir_read;     // level: matched, high direction bit being clocked
    logic gc_addr;      // general call write address seen (pulse)
    logic byte_done;    // data byte complete (pulse)
    logic last_bit;     // level: last data bit of a byte being clocked
    logic tx_data_req;  // level: master is reading data
  } tsf_link_evt_s;
  // Same-clock FIFO levels and strobes
  typedef struct packed {
    logic rx_push;
    logic rx_full;
    logic rx_not_empty;
    logic tx_empty;
    logic tx_full;
  } tsf_fifo_s;
  typedef enum logic [1:0] { GC_IDLE, GC_WAIT_BYTE } tsf_gc_state_e;
endpackage : tsf_pkg

// ---- rtl/tsf_sync.sv ----
// Two-flop synchroniser with edge detection on the synchronised level.
// Assumes an asynchronous input and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tsf_sync (
  input  wire logic clk_sys_i,  // system clock
  input  wire logic reset_i,    // sync reset
  input  wire logic async_i,    // raw pin
  output logic      level_o,    // synchronised level
  output logic      rise_o,     // one-cycle rising pulse
  output logic      fall_o      // one-cycle falling pulse
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;
  assign fall_o  = ~sync_q & last_q;
endmodule : tsf_sync
`default_nettype wire

// ---- rtl/tsf_ahb_slave.sv ----
// AHB-Lite slave front end: zero wait states, always OKAY.
// Assumes single word transfers; read data is sampled at address phase.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_consts.svh"
module tsf_ahb_slave import tsf_pkg::*; (
  input  wire logic        clk_sys_i,   // system clock
  input  wire logic        reset_i,     // sync reset
  input  wire logic        hsel_i,      // slave select
  input  wire logic [7:0]  haddr_i,     // byte address (low bits)
  input  wire logic [1:0]  htrans_i,    // transfer type
  input  wire logic        hwrite_i,    // write
  input  wire logic        hready_i,    // bus ready
  input  wire logic [31:0] rdata_i,     // read mux for haddr_i
  output logic             hreadyout_o, // always ready
  output logic             hresp_o,     // always OKAY
  output logic [31:0]      hrdata_o,    // registered read data
  output logic             wr_o,        // data phase write strobe
  output logic             rd_o,        // data phase read strobe
  output logic [7:0]       addr_o       // data phase address
);
  logic       take_w;
  logic       wr_q;
  logic       rd_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  assign take_w = hsel_i & htrans_i[1] & hready_i;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      addr_q   <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q     <= take_w & hwrite_i;
      rd_q     <= take_w & ~hwrite_i;
      if (take_w) addr_q <= haddr_i;
      if (take_w & ~hwrite_i) hrdata_q <= rdata_i;
    end
  end
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_q;
  assign wr_o        = wr_q;
  assign rd_o        = rd_q;
  assign addr_o      = addr_q;
endmodule : tsf_ahb_slave
`default_nettype wire

// ---- rtl/tsf_status.sv ----
// Target status and event flags with AHB-Lite register access.
// Assumes a shift engine on clk_sys_i supplying events and FIFO levels;
// SCL arrives raw from the pin and is synchronised here.
// Function
// RL1 - Gencall type clears only when software writes one to gencall clear
// RL2 - Type 00 none, 01 reset+program, 10 program, 11 alternative id
// RL3 - Gencall reset sets the gencall type field to 01; the reset it requests does not clear it
// RL4 - Any gencall sets gencall irq flag, which always drives interrupt
// RL5 - Gencall irq flag holds until software writes one to gencall clear
// RL6 - Gencall reset request restores all registers to defaults; gencall type and irq are kept
// RL7 - Hardware gencall keeps the second byte in the receive FIFO
// RL8 - Start condition sets the target busy flag
// RL9 - Busy clears on address miss, stop, or repeated-start address miss
// RL10 - Refused ack set on read with empty FIFO or forced refuse
// RL11 - Status read clears the refused ack flag
// RL12 - Push into full receive FIFO sets overflow; status read clears
// RL13 - Receive request follows FIFO not empty, clears when empty
// RL14 - Receive request rises at SCL fall of the byte's last bit
// RL15 - Receive request can raise the interrupt
// RL16 - Normal mode: tx request at SCL fall of high direction bit
// RL17 - Early mode: tx request just after SCL rise of direction bit
// RL18 - Status read clears the tx request flag
// RL19 - Read request with empty tx FIFO at SCL rise sets underflow
// RL20 - Normal mode: tx empty/early flag shows FIFO empty; resets to 1
// RL21 - Early mode: flag pulses once per transfer at SCL rise
// RL22 - Hardware gencall needs both enables and second byte equal to alt
// RL23 - Gencall address acknowledged only when gencall enable is set
// RL24 - Status read returns old values; clears land after the read
`timescale 1ns/1ps
`default_nettype none
`include "tsf_consts.svh"
module tsf_status import tsf_pkg::*; (
  input  wire logic        clk_sys_i,     // 100 MHz system clock
  input  wire logic        reset_i,       // sync reset, active high
  input  wire logic        hsel_i,        // AHB select
  input  wire logic [31:0] haddr_i,       // AHB address
  input  wire logic [1:0]  htrans_i,      // AHB transfer type
  input  wire logic        hwrite_i,      // AHB write
  input  wire logic [2:0]  hsize_i,       // AHB size (word only)
  input  wire logic [31:0] hwdata_i,      // AHB write data
  input  wire logic        hready_i,      // AHB ready
  output logic             hreadyout_o,   // AHB ready out
  output logic             hresp_o,       // AHB response
  output logic [31:0]      hrdata_o,      // AHB read data
  input  wire logic        scl_i,         // raw SCL pin
  input  wire tsf_link_evt_s evt_i,       // engine events
  input  wire tsf_fifo_s   fifo_i,        // FIFO levels
  input  wire logic [7:0]  rx_byte_i,     // byte shifted in
  output logic             irq_o,         // target interrupt request
  output logic             force_refuse_ack_o,        // refuse ack of own address
  output logic             gc_ack_o,      // ack general call address
  output logic             gc_reset_o,    // pulse: reset rest of target
  output logic             gc_keep_byte_o // pulse: keep byte in rx FIFO
);
  logic scl_rise_w;
  logic scl_fall_w;
  logic        bus_wr_w;
  logic        bus_rd_w;
  logic [7:0]  bus_addr_w;
  logic [31:0] rdata_w;

  tsf_sync u_scl_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .async_i   (scl_i),
    .level_o   (),
    .rise_o    (scl_rise_w),
    .fall_o    (scl_fall_w)
  );

  tsf_ahb_slave u_ahb (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i[7:0]),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hready_i    (hready_i),
    .rdata_i     (rdata_w),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .hrdata_o    (hrdata_o),
    .wr_o        (bus_wr_w),
    .rd_o        (bus_rd_w),
    .addr_o      (bus_addr_w)
  );

  // Software-visible and internal state
  logic [4:0]  ctrl_q;
  logic [4:0]  ctrl_d;
  logic [7:0]  alt_q;
  logic [7:0]  alt_d;
  logic [1:0]  gc_type_q;
  logic [1:0]  gc_type_d;
  logic        gc_irq_q;
  logic        gc_irq_d;
  logic        busy_q;
  logic        busy_d;
  logic        refused_q;
  logic        refused_d;
  logic        rxof_q;
  logic        rxof_d;
  logic        rxreq_q;
  logic        rxreq_d;
  logic        txreq_q;
  logic        txreq_d;
  logic        txur_q;
  logic        txur_d;
  logic        txee_q;
  logic        txee_d;
  logic        tx_armed_q;
  logic        tx_armed_d;
  logic        early_done_q;
  logic        early_done_d;
  tsf_gc_state_e gc_st_q;
  tsf_gc_state_e gc_st_d;
  logic        irq_q;
  logic        force_refuse_ack_q;
  logic        gc_ack_q;
  logic        gc_reset_q;
  logic        gc_keep_q;

  // Register decode
  logic        wr_ctrl_w;
  logic        wr_alt_w;
  logic        rd_stat_w;
  logic        gc_clear_w;
  logic        force_force_refuse_ack_w;
  logic        early_w;
  logic        gc_en_w;
  logic        hwgc_en_w;
  logic [15:0] status_w;
  assign wr_ctrl_w   = bus_wr_w & (bus_addr_w == `TSF_OFS_CONTROL);
  assign wr_alt_w    = bus_wr_w & (bus_addr_w == `TSF_OFS_ALT);
  // RL24 clear after read
  assign rd_stat_w   = bus_rd_w & (bus_addr_w == `TSF_OFS_STATUS);
  assign gc_clear_w  = wr_ctrl_w & hwdata_i[`TSF_CT_GCCLR];
  assign force_force_refuse_ack_w = ctrl_q[`TSF_CT_FORCE_FORCE_REFUSE_ACK];
  assign early_w     = ctrl_q[`TSF_CT_EARLY_TX];
  assign gc_en_w     = ctrl_q[`TSF_CT_GC_EN];
  assign hwgc_en_w   = ctrl_q[`TSF_CT_HWGC_EN];
  assign status_w    = {6'h00, gc_type_q, gc_irq_q, busy_q, refused_q,
                        rxof_q, rxreq_q, txreq_q, txur_q, txee_q};
  // Read mux is sampled at the address phase, before any clear lands
  assign rdata_w =
    (haddr_i[7:0] == `TSF_OFS_STATUS)  ? {16'h0000, status_w} :
    (haddr_i[7:0] == `TSF_OFS_CONTROL) ? {27'h0, ctrl_q[4:1], 1'b0} :
    (haddr_i[7:0] == `TSF_OFS_ALT)     ? {24'h000000, alt_q} :
                                         32'h0000_0000;

  // General call decode of the second byte
  logic gc_byte_w;
  logic gc_is_reset_w;
  logic gc_is_prog_w;
  logic gc_is_hw_w;
  logic gc_event_w;
  logic [1:0] gc_code_w;
  assign gc_byte_w     = (gc_st_q == GC_WAIT_BYTE) & evt_i.byte_done;
  // RL2 type encoding
  assign gc_is_reset_w = gc_byte_w & (rx_byte_i == `TSF_GC_CMD_RESET);
  assign gc_is_prog_w  = gc_byte_w & (rx_byte_i == `TSF_GC_CMD_PROG);
  // RL22 both enables and alt match
  assign gc_is_hw_w    = gc_byte_w & gc_en_w & hwgc_en_w &
                         (rx_byte_i == alt_q);
  assign gc_event_w    = gc_is_reset_w | gc_is_prog_w | gc_is_hw_w;
  assign gc_code_w     = gc_is_reset_w ? `TSF_GC_RESET_PROG :
                         gc_is_prog_w  ? `TSF_GC_PROG : `TSF_GC_HW;

  always_comb begin
    gc_st_d = gc_st_q;
    unique case (gc_st_q)
      GC_IDLE: begin
        // RL23 only enabled gencall is followed
        if (evt_i.gc_addr & gc_en_w) gc_st_d = GC_WAIT_BYTE;
      end
      GC_WAIT_BYTE: begin
        if (evt_i.byte_done | evt_i.start | evt_i.stop) gc_st_d = GC_IDLE;
      end
      default: gc_st_d = GC_IDLE;
    endcase
  end

  // Transmit qualification on SCL edges and address match
  logic tx_set_w;
  logic early_set_w;
  logic refuse_w;
  // RL16 normal mode at SCL fall
  // RL17 early mode at SCL rise
  assign tx_set_w    = evt_i.dir_read &
                       (early_w ? scl_rise_w : scl_fall_w);
  // RL21 once per transfer
  assign early_set_w = early_w & evt_i.dir_read & scl_rise_w &
                       ~early_done_q;
  // RL10 refuse conditions
  assign refuse_w    = evt_i.addr_match &
                       (force_force_refuse_ack_w | (evt_i.dir_read & fifo_i.tx_empty));

  always_comb begin
    // RL1 RL5 clear by write, set wins
    gc_type_d = gc_event_w ? gc_code_w :
                gc_clear_w ? `TSF_GC_NONE : gc_type_q;
    // RL4 any gencall sets irq
    gc_irq_d  = gc_event_w | (gc_irq_q & ~gc_clear_w);
    // RL8 RL9 busy tracking
    busy_d    = evt_i.start |
                (busy_q & ~(evt_i.addr_nomatch | evt_i.stop |
                            evt_i.rsta_nomatch));
    // RL11 refused ack clear on read
    refused_d = refuse_w | (refused_q & ~rd_stat_w);
    // RL12 overflow on push when full
    rxof_d    = (fifo_i.rx_push & fifo_i.rx_full) | (rxof_q & ~rd_stat_w);
    // RL13 RL14 set at last-bit fall, up while not empty
    // A late FIFO push still raises the request
    rxreq_d   = (scl_fall_w & evt_i.last_bit) | fifo_i.rx_not_empty;
    tx_armed_d = tx_set_w |
                 (tx_armed_q & ~(evt_i.stop | evt_i.start | rd_stat_w));
    // RL18 tx request clear on read
    txreq_d   = tx_set_w | (tx_armed_q & ~fifo_i.tx_full & ~rd_stat_w);
    // RL19 underflow at SCL rise
    txur_d    = (evt_i.tx_data_req & fifo_i.tx_empty & scl_rise_w) |
                (txur_q & ~rd_stat_w);
    // RL20 RL21 tx empty or early pulse
    txee_d    = early_w ? (early_set_w | (txee_q & ~rd_stat_w))
                        : fifo_i.tx_empty;
    early_done_d = early_set_w |
                   (early_done_q & ~(evt_i.stop | evt_i.start));
    ctrl_d    = wr_ctrl_w ? {hwdata_i[4:1], 1'b0} : ctrl_q;
    alt_d     = wr_alt_w ? hwdata_i[7:0] : alt_q;
  end

  always_ff @(posedge clk_sys_i) begin
    // RL6 gencall reset restores defaults
    // RL3 type and irq survive the gencall reset
    if (reset_i | gc_is_reset_w) begin
      ctrl_q       <= `TSF_RST_CONTROL;
      alt_q        <= `TSF_RST_ALT;
      busy_q       <= 1'b0;
      refused_q    <= 1'b0;
      rxof_q       <= 1'b0;
      rxreq_q      <= 1'b0;
      txreq_q      <= 1'b0;
      txur_q       <= 1'b0;
      txee_q       <= `TSF_RST_TXEE;
      tx_armed_q   <= 1'b0;
      early_done_q <= 1'b0;
      force_refuse_ack_q       <= 1'b0;
      gc_ack_q     <= 1'b0;
    end else begin
      ctrl_q       <= ctrl_d;
      alt_q        <= alt_d;
      busy_q       <= busy_d;
      refused_q    <= refused_d;
      rxof_q       <= rxof_d;
      rxreq_q      <= rxreq_d;
      txreq_q      <= txreq_d;
      txur_q       <= txur_d;
      txee_q       <= txee_d;
      tx_armed_q   <= tx_armed_d;
      early_done_q <= early_done_d;
      force_refuse_ack_q       <= force_force_refuse_ack_w | fifo_i.tx_empty;
      // RL23 gencall ack follows enable
      gc_ack_q     <= gc_en_w;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      gc_type_q  <= `TSF_GC_NONE;
      gc_irq_q   <= 1'b0;
      gc_st_q    <= GC_IDLE;
      irq_q      <= 1'b0;
      gc_reset_q <= 1'b0;
      gc_keep_q  <= 1'b0;
    end else begin
      gc_type_q  <= gc_type_d;
      gc_irq_q   <= gc_irq_d;
      gc_st_q    <= gc_st_d;
      // RL4 RL15 interrupt sources
      irq_q      <= gc_irq_d | rxreq_d;
      gc_reset_q <= gc_is_reset_w;
      // RL7 keep second byte
      gc_keep_q  <= gc_is_hw_w & ~gc_is_reset_w & ~gc_is_prog_w;
    end
  end

  assign irq_o          = irq_q;
  assign force_refuse_ack_o         = force_refuse_ack_q;
  assign gc_ack_o       = gc_ack_q;
  assign gc_reset_o     = gc_reset_q;
  assign gc_keep_byte_o = gc_keep_q;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_gc_type_hold: assert property ( // RL1
    !gc_event_w && !gc_clear_w |=> $stable(gc_type_q))
    else $error("gencall type changed without cause");
  a_gc_irq_set: assert property ( // RL4
    gc_event_w |=> gc_irq_q && irq_q)
    else $error("gencall did not raise irq");
  a_gc_irq_hold: assert property ( // RL5
    gc_irq_q && !gc_clear_w |=> gc_irq_q)
    else $error("gencall irq dropped without clear");
  a_gc_reset_keep: assert property ( // RL3
    gc_is_reset_w |=> gc_type_q == `TSF_GC_RESET_PROG && ctrl_q == 5'h00)
    else $error("gencall reset handling wrong");
  a_busy_start: assert property ( // RL8
    evt_i.start |=> busy_q)
    else $error("busy not set on start");
  a_busy_stop: assert property ( // RL9
    evt_i.stop && !evt_i.start |=> !busy_q)
    else $error("busy not cleared on stop");
  a_refused_read: assert property ( // RL11
    rd_stat_w && !refuse_w && !gc_is_reset_w |=> !refused_q)
    else $error("refused ack not cleared by read");
  a_rxof_set: assert property ( // RL12
    fifo_i.rx_push && fifo_i.rx_full && !gc_is_reset_w |=> rxof_q)
    else $error("overflow not flagged");
  a_rxreq_edge: assert property ( // RL14
    scl_fall_w && evt_i.last_bit && !gc_is_reset_w |=> rxreq_q && irq_q)
    else $error("receive request missed");
  a_txur_set: assert property ( // RL19
    evt_i.tx_data_req && fifo_i.tx_empty && scl_rise_w && !gc_is_reset_w
    |=> txur_q)
    else $error("underflow not flagged");
  a_txee_normal: assert property ( // RL20
    !early_w && !gc_is_reset_w |=> txee_q == $past(fifo_i.tx_empty))
    else $error("tx empty flag wrong");
  a_txreq_early: assert property ( // RL17
    early_w && evt_i.dir_read && scl_rise_w && !gc_is_reset_w |=> txreq_q)
    else $error("early tx request missed");
  a_rxreq_level: assert property ( // RL13
    fifo_i.rx_not_empty && !gc_is_reset_w |=> rxreq_q)
    else $error("receive request not following fifo");
  a_txreq_read: assert property ( // RL18
    rd_stat_w && !tx_set_w && !gc_is_reset_w |=> !txreq_q)
    else $error("tx request not cleared by read");
  a_refused_set: assert property ( // RL10
    refuse_w && !gc_is_reset_w |=> refused_q)
    else $error("refused ack not flagged");
  a_gc_addr_off: assert property ( // RL23
    gc_st_q == GC_IDLE && evt_i.gc_addr && !gc_en_w |=> gc_st_q == GC_IDLE)
    else $error("disabled gencall address followed");
endmodule : tsf_status
`default_nettype wire

// ---- bench/tsf_link_model.sv ----
// Behavioural model of the external controller's SCL line.
// Assumes the bench calls rise and fall; SCL idles high on its pull-up
// and stands still between calls.
`timescale 1ns/1ps
`default_nettype none
module tsf_link_model (
  output logic scl_o  // SCL as seen at the target pin
);
  initial scl_o = 1'b1;
  // Half of a 125 ns SCL period per level
  task automatic rise();
    scl_o <= 1'b1;
    #62.5;
  endtask : rise
  task automatic fall();
    scl_o <= 1'b0;
    #62.5;
  endtask : fall
endmodule : tsf_link_model
`default_nettype wire

// ---- bench/tsf_status_tb.sv ----
// Self-checking bench for the target status flag block.
// Assumes the link model drives SCL and the bench drives engine events.
`timescale 1ns/1ps
`default_nettype none
`include "tsf_consts.svh"
module tsf_status_tb import tsf_pkg::*; ;
  localparam tsf_link_evt_s E_START = '{start: 1'b1, default: 1'b0};
  localparam tsf_link_evt_s E_STOP = '{stop: 1'b1, default: 1'b0};
  localparam tsf_link_evt_s E_MATCH = '{addr_match: 1'b1, default: 1'b0};
  localparam tsf_link_evt_s E_MISS = '{addr_nomatch: 1'b1, default: 1'b0};
  localparam tsf_link_evt_s E_RMISS = '{rsta_nomatch: 1'b1, default: 1'b0};
  localparam tsf_link_evt_s E_GC = '{gc_addr: 1'b1, default: 1'b0};
  localparam tsf_link_evt_s E_BYTE = '{byte_done: 1'b1, default: 1'b0};
  logic          clk_sys_i = 1'b0;
  logic          reset_i   = 1'b1;
  logic [31:0]   haddr     = '0;
  logic [1:0]    htrans    = 2'h0;
  logic          hwrite    = 1'b0;
  logic [31:0]   hwdata    = '0;
  logic [7:0]    rx_byte   = '0;
  logic [31:0]   rd;
  tsf_link_evt_s evt       = '0;
  tsf_fifo_s     fifo      = '{tx_empty: 1'b1, default: 1'b0};
  tsf_link_evt_s ends [3]  = '{E_STOP, E_MISS, E_RMISS};
  logic [7:0]    gc_b [3]  = '{`TSF_GC_CMD_PROG, `TSF_GC_CMD_RESET, 8'h55};
  logic [1:0]    gc_t [3]  = '{`TSF_GC_PROG, `TSF_GC_RESET_PROG, `TSF_GC_HW};
  wire           hready, hresp, irq, force_refuse_ack, gc_ack, gc_rst, gc_keep, scl;
  wire  [31:0]   hrdata;
  int            errors = 0;
  int            cmp_count = 0;
  int            n_rst = 0;
  int            n_keep = 0;
  int            r0, k0;

  always #5 clk_sys_i = ~clk_sys_i;

  tsf_status i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .scl_i(scl), .evt_i(evt), .fifo_i(fifo), .rx_byte_i(rx_byte),
    .irq_o(irq), .force_refuse_ack_o(force_refuse_ack), .gc_ack_o(gc_ack), .gc_reset_o(gc_rst),
    .gc_keep_byte_o(gc_keep));
  tsf_link_model i_link (.scl_o(scl));

  // Count one-cycle pulses so no edge is missed
  always @(posedge clk_sys_i) begin
    if (gc_rst === 1'b1) n_rst++;
    if (gc_keep === 1'b1) n_keep++;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        $display("Error hready expected 1 seen %b", hready);
        final_report();
      end
      @(posedge clk_sys_i);
    end
  endtask : wait_ready

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask : wr

  task automatic chk_st(input logic [31:0] mask, input logic [31:0] exp);
    ahb(1'b0, `TSF_OFS_STATUS, 32'h0, rd);
    chk("status", rd & mask, exp);
  endtask : chk_st

  task automatic pulse(input tsf_link_evt_s p);
    // Touch only the pulsed bits so pending level changes survive
    for (int k = 0; k < $bits(p); k++)
      if (p[k]) evt[k] <= 1'b1;
    @(posedge clk_sys_i);
    for (int k = 0; k < $bits(p); k++)
      if (p[k]) evt[k] <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask : pulse

  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    chk_st(32'hffff, 32'h0001);
    ahb(1'b0, `TSF_OFS_CONTROL, 32'h0, rd);
    chk("control", rd, 32'h0);
    ahb(1'b0, 8'h0c, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    chk("hresp_o", {31'h0, hresp}, 32'h0);
    $display("Test reset done");
    foreach (ends[i]) begin
      pulse(E_START);
      chk_st(32'h40, 32'h40);
      pulse(ends[i]);
      chk_st(32'h40, 32'h0);
    end
    $display("Test busy done");
    fifo.tx_empty <= 1'b0;
    pulse(E_MATCH);
    i_link.fall();
    evt.dir_read <= 1'b1;
    i_link.rise();
    chk_st(32'h4, 32'h0);
    i_link.fall();
    chk_st(32'h5, 32'h4);
    fifo.tx_empty <= 1'b1;
    @(posedge clk_sys_i);
    chk_st(32'h5, 32'h1);
    wr(`TSF_OFS_CONTROL, 32'h4);
    fifo.tx_empty <= 1'b0;
    pulse(E_MATCH);
    i_link.rise();
    chk_st(32'h5, 32'h5);
    chk_st(32'h5, 32'h0);
    i_link.fall();
    i_link.rise();
    chk_st(32'h1, 32'h0);
    evt.dir_read <= 1'b0;
    wr(`TSF_OFS_CONTROL, 32'h0);
    $display("Test transmit request done");
    evt.tx_data_req <= 1'b1;
    fifo.tx_empty <= 1'b1;
    i_link.fall();
    i_link.rise();
    chk_st(32'h2, 32'h2);
    chk_st(32'h2, 32'h0);
    evt.tx_data_req <= 1'b0;
    fifo.tx_empty <= 1'b0;
    ahb(1'b0, `TSF_OFS_STATUS, 32'h0, rd);
    chk("force_refuse_ack_o", {31'h0, force_refuse_ack}, 32'h0);
    wr(`TSF_OFS_CONTROL, 32'h2);
    repeat (2) @(posedge clk_sys_i);
    chk("force_refuse_ack_o", {31'h0, force_refuse_ack}, 32'h1);
    pulse(E_MATCH);
    chk_st(32'h20, 32'h20);
    chk_st(32'h20, 32'h0);
    wr(`TSF_OFS_CONTROL, 32'h0);
    $display("Test underflow and refusal done");
    fifo.rx_full <= 1'b1;
    fifo.rx_push <= 1'b1;
    @(posedge clk_sys_i);
    fifo.rx_push <= 1'b0;
    fifo.rx_full <= 1'b0;
    chk_st(32'h10, 32'h10);
    chk_st(32'h10, 32'h0);
    i_link.fall();
    evt.last_bit <= 1'b1;
    i_link.rise();
    chk("irq_o", {31'h0, irq}, 32'h0);
    i_link.fall();
    fifo.rx_not_empty <= 1'b1;
    evt.last_bit <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk("irq_o", {31'h0, irq}, 32'h1);
    chk_st(32'h8, 32'h8);
    chk_st(32'h8, 32'h8);
    fifo.rx_not_empty <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk_st(32'h8, 32'h0);
    i_link.rise();
    $display("Test receive done");
    chk("gc_ack_o", {31'h0, gc_ack}, 32'h0);
    pulse(E_GC);
    pulse(E_BYTE);
    chk_st(32'h380, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`TSF_OFS_ALT, 32'h55);
      wr(`TSF_OFS_CONTROL, 32'h18);
      repeat (2) @(posedge clk_sys_i);
      chk("gc_ack_o", {31'h0, gc_ack}, 32'h1);
      r0 = n_rst;
      k0 = n_keep;
      rx_byte <= gc_b[i];
      pulse(E_GC);
      pulse(E_BYTE);
      chk_st(32'h380, {22'h0, gc_t[i], 8'h80});
      chk_st(32'h380, {22'h0, gc_t[i], 8'h80});
      chk("irq_o", {31'h0, irq}, 32'h1);
      chk("gc_reset_o", 32'(n_rst - r0), 32'(i == 1));
      chk("gc_keep_o", 32'(n_keep - k0), 32'(i == 2));
      ahb(1'b0, `TSF_OFS_CONTROL, 32'h0, rd);
      chk("control", rd, (i == 1) ? 32'h0 : 32'h18);
      wr(`TSF_OFS_CONTROL, 32'h1);
      chk_st(32'h380, 32'h0);
      chk("irq_o", {31'h0, irq}, 32'h0);
    end
    $display("Test general call done");
    final_report();
  end
endmodule : tsf_status_tb
`default_nettype wire
